//--- rtl/local_global_address_mapper.sv
/*
 Local to global address mapper with its page registers on an
 Avalon-MM slave with waitrequest.
 Assumes the core presents one local access per request cycle and
 that the bus master holds a request until waitrequest is low.
*/
`timescale 1ns/10ps
`include "mapper_regs.svh"
module local_global_address_mapper #(
	parameter int AVS_ADDR_W = 3
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic [AVS_ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic lcl_req_in,
	input wire logic [15:0] lcl_addr_in,
	input wire logic lcl_global_in,
	input wire logic lcl_direct_in,
	output logic gbl_valid_out,
	output logic [22:0] gbl_addr_out,
	output logic [2:0] gbl_block_out
);

	mapper_pkg::bus_state_t bus_state_r;
	mapper_pkg::bus_state_t bus_state_nxt;
	logic waitrequest_r;
	logic [31:0] readdata_r;
	logic [6:0] global_page_r;
	logic [7:0] direct_page_r;
	logic direct_locked_r;
	logic [7:0] eeprom_page_r;
	logic [7:0] ram_page_r;
	logic [7:0] program_page_r;
	logic gbl_valid_r;
	logic [22:0] gbl_addr_r;
	mapper_pkg::block_t gbl_block_r;

	window_if eep_win ();
	window_if ram_win ();
	window_if pfl_win ();

	// Effective local address

	wire [15:0] eff_addr;
	wire in_regs;
	wire in_eep;
	wire in_ram;
	wire in_fixed_low;
	wire in_pwin;
	wire [22:0] global_form;
	wire [22:0] regs_form;
	wire [22:0] local_form;
	wire [22:0] mapped_addr;
	mapper_pkg::block_t mapped_block;

	// RULE4 direct page high byte
	assign eff_addr = lcl_direct_in ? {direct_page_r, lcl_addr_in[7:0]} : lcl_addr_in;

	// RULE3 registers at zero
	assign in_regs = eff_addr < `LCL_EEP_START;
	// RULE6 EEPROM local range
	assign in_eep = (eff_addr >= `LCL_EEP_START) && (eff_addr < `LCL_RAM_START);
	// RULE10 RAM local range
	assign in_ram = (eff_addr >= `LCL_RAM_START) && (eff_addr < `LCL_FLASH_START);
	assign in_fixed_low = (eff_addr >= `LCL_FLASH_START) && (eff_addr < `LCL_PWIN_START);
	// RULE14 program window range
	assign in_pwin = (eff_addr >= `LCL_PWIN_START) && (eff_addr < `LCL_FIXED_TOP);

	// Window page selection

	// RULE6 upper kilobyte fixed
	// RULE7 lower kilobyte paged
	assign eep_win.page = eff_addr[`LCL_EEP_FIXED_BIT] ? `EEP_FIXED_PAGE : eeprom_page_r;
	assign eep_win.offset = eff_addr[13:0];

	// RULE11 fixed halves as pages
	assign ram_win.page = eff_addr[`LCL_RAM_FIXED_BIT] ?
		{`RAM_FIXED_HI, eff_addr[`LCL_RAM_HALF_BIT]} : ram_page_r;
	assign ram_win.offset = eff_addr[13:0];

	// RULE16 fixed flash pages
	assign pfl_win.page = in_fixed_low ? `PFL_LOW_FIXED_PAGE :
		(in_pwin ? program_page_r : `PFL_TOP_FIXED_PAGE);
	assign pfl_win.offset = eff_addr[13:0];

	// RULE8 EEPROM global base
	// RULE9 fixed page at top
	page_window #(
		.OFF_W(`EEP_OFF_W),
		.BASE(`GBL_EEP_BASE)
	) u_eep_window (
		.win(eep_win.window)
	);

	// RULE12 RAM global base
	page_window #(
		.OFF_W(`RAM_OFF_W),
		.BASE(`GBL_RAM_BASE)
	) u_ram_window (
		.win(ram_win.window)
	);

	// RULE15 16K program pages
	page_window #(
		.OFF_W(`PFL_OFF_W),
		.BASE(`GBL_PFL_BASE)
	) u_pfl_window (
		.win(pfl_win.window)
	);

	// Final address selection

	// RULE1 global page on top
	assign global_form = {global_page_r, lcl_addr_in};
	assign regs_form = 23'(eff_addr);

	// RULE2 disjoint regions, no relocation
	assign local_form = in_regs ? regs_form :
		(in_eep ? eep_win.gaddr :
		(in_ram ? ram_win.gaddr : pfl_win.gaddr));

	assign mapped_addr = lcl_global_in ? global_form : local_form;

	// RULE13 five block types
	function automatic mapper_pkg::block_t classify(input logic [22:0] ga);
		mapper_pkg::block_t blk;
		blk = mapper_pkg::BLK_EXTERNAL;
		if (ga <= `GBL_REG_END) begin
			blk = mapper_pkg::BLK_REGS;
		end else if (ga >= `GBL_RAM_START && ga <= `GBL_RAM_END) begin
			blk = mapper_pkg::BLK_RAM;
		end else if (ga >= `GBL_EEP_BASE && ga <= `GBL_EEP_END) begin
			blk = mapper_pkg::BLK_EEPROM;
		end else if (ga >= `GBL_PFL_BASE && ga <= `GBL_PFL_END) begin
			blk = mapper_pkg::BLK_FLASH;
		end
		return blk;
	endfunction

	assign mapped_block = classify(mapped_addr);

	// One cycle translation stage; keeps the output free of glitches
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			gbl_valid_r <= 1'b0;
			gbl_addr_r <= 23'h00_0000;
			gbl_block_r <= mapper_pkg::BLK_REGS;
		end else begin
			gbl_valid_r <= lcl_req_in;
			if (lcl_req_in) begin
				gbl_addr_r <= mapped_addr;
				gbl_block_r <= mapped_block;
			end
		end
	end

	// Register bus decode

	wire hit_global;
	wire hit_direct;
	wire hit_eeprom;
	wire hit_ram;
	wire hit_program;
	wire hit_status;
	wire hit_last;
	wire commit_write;
	wire low_lane;
	wire direct_take;
	wire [31:0] status_word;
	wire [31:0] rd_mux;

	assign hit_global = avs_address_in == `OFS_GLOBAL_PAGE;
	assign hit_direct = avs_address_in == `OFS_DIRECT_PAGE;
	assign hit_eeprom = avs_address_in == `OFS_EEPROM_PAGE;
	assign hit_ram = avs_address_in == `OFS_RAM_PAGE;
	assign hit_program = avs_address_in == `OFS_PROGRAM_PAGE;
	assign hit_status = avs_address_in == `OFS_STATUS;
	assign hit_last = avs_address_in == `OFS_LAST_GLOBAL;

	// Writes land only on the edge that ends the answer cycle
	assign commit_write = (bus_state_r == mapper_pkg::BUS_ANSWER) && avs_write_in;
	assign low_lane = avs_byteenable_in[0];

	// RULE5 first write locks
	assign direct_take = commit_write && low_lane && hit_direct && !direct_locked_r;

	assign status_word = (32'(gbl_block_r) << `STS_BLOCK_LSB) |
		(32'(direct_locked_r) << `STS_LOCK_BIT);

	// Unmapped offsets read as zero
	assign rd_mux = hit_global ? 32'(global_page_r) :
		hit_direct ? 32'(direct_page_r) :
		hit_eeprom ? 32'(eeprom_page_r) :
		hit_ram ? 32'(ram_page_r) :
		hit_program ? 32'(program_page_r) :
		hit_status ? status_word :
		hit_last ? 32'(gbl_addr_r) :
		32'h0000_0000;

	// Bus handshake

	always_comb begin
		bus_state_nxt = bus_state_r;
		case (bus_state_r)
			mapper_pkg::BUS_IDLE: begin
				if (avs_read_in || avs_write_in) begin
					bus_state_nxt = mapper_pkg::BUS_ANSWER;
				end
			end
			mapper_pkg::BUS_ANSWER: begin
				bus_state_nxt = mapper_pkg::BUS_IDLE;
			end
			default: begin
				bus_state_nxt = mapper_pkg::BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			bus_state_r <= mapper_pkg::BUS_IDLE;
			waitrequest_r <= 1'b1;
			readdata_r <= 32'h0000_0000;
		end else begin
			bus_state_r <= bus_state_nxt;
			waitrequest_r <= bus_state_nxt != mapper_pkg::BUS_ANSWER;
			if (bus_state_r == mapper_pkg::BUS_IDLE && avs_read_in) begin
				readdata_r <= rd_mux;
			end
		end
	end

	// Page registers

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			global_page_r <= `RST_GLOBAL_PAGE;
			eeprom_page_r <= `RST_EEPROM_PAGE;
			ram_page_r <= `RST_RAM_PAGE;
			program_page_r <= `RST_PROGRAM_PAGE;
		end else if (commit_write && low_lane) begin
			if (hit_global) begin
				global_page_r <= avs_writedata_in[6:0];
			end
			if (hit_eeprom) begin
				eeprom_page_r <= avs_writedata_in[7:0];
			end
			if (hit_ram) begin
				ram_page_r <= avs_writedata_in[7:0];
			end
			if (hit_program) begin
				program_page_r <= avs_writedata_in[7:0];
			end
		end
	end

	// Lock survives until reset; a later write is dropped silently
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			direct_page_r <= `RST_DIRECT_PAGE;
			direct_locked_r <= 1'b0;
		end else if (direct_take) begin
			// RULE5 single write accepted
			direct_page_r <= avs_writedata_in[7:0];
			direct_locked_r <= 1'b1;
		end
	end

	assign avs_readdata_out = readdata_r;
	assign avs_waitrequest_out = waitrequest_r;
	assign gbl_valid_out = gbl_valid_r;
	assign gbl_addr_out = gbl_addr_r;
	assign gbl_block_out = gbl_block_r;

endmodule

//--- rtl/mapper_pkg.sv
/*
 Types of the local to global address mapper.
 Assumes the constants header is compiled alongside.
*/
package mapper_pkg;

	typedef enum logic [2:0] {
		BLK_REGS = 3'h0,
		BLK_RAM = 3'h1,
		BLK_EEPROM = 3'h2,
		BLK_FLASH = 3'h3,
		BLK_EXTERNAL = 3'h4
	} block_t;

	typedef enum logic {
		BUS_IDLE = 1'b0,
		BUS_ANSWER = 1'b1
	} bus_state_t;

endpackage

//--- rtl/mapper_regs.svh
/*
 Constants of the local to global address mapper: register word offsets,
 reset values, region bounds and global bases.
 Assumes inclusion by bare name; definitions only.
*/
// What this block does
// RULE1 - Fixed local to global map, global page top
// RULE2 - No relocation; blocks never overlay each other
// RULE3 - Register block fixed at local zero
// RULE4 - Direct page register forms upper address byte
// RULE5 - Direct page register takes one write only
// RULE6 - Local 0x0800-0x0FFF is EEPROM, upper fixed
// RULE7 - Lower EEPROM kilobyte paged by EEPROM page
// RULE8 - EEPROM/data flash at global 0x10_0000-0x13_FFFF
// RULE9 - EEPROM top pages, data flash bottom pages
// RULE10 - Local 0x1000-0x3FFF is RAM, upper fixed
// RULE11 - Lower RAM 4K paged, fixed halves selectable
// RULE12 - RAM global from 0x00_1000 to 0x0F_FFFF
// RULE13 - Five block types, one standard map
// RULE14 - Local 0x8000-0xBFFF paged program flash window
// RULE15 - Program page zero at 0x40_0000, 16K steps
// RULE16 - Fixed flash windows at 0x7F_4000, 0x7F_C000
// RULE17 - Window address is base plus shifted page
`ifndef MAPPER_REGS_SVH
`define MAPPER_REGS_SVH

`define OFS_GLOBAL_PAGE 3'h0
`define OFS_DIRECT_PAGE 3'h1
`define OFS_EEPROM_PAGE 3'h2
`define OFS_RAM_PAGE 3'h3
`define OFS_PROGRAM_PAGE 3'h4
`define OFS_STATUS 3'h5
`define OFS_LAST_GLOBAL 3'h6

`define RST_GLOBAL_PAGE 7'h00
`define RST_DIRECT_PAGE 8'h00
`define RST_EEPROM_PAGE 8'hFE
`define RST_RAM_PAGE 8'hFD
`define RST_PROGRAM_PAGE 8'hFE

`define LCL_EEP_START 16'h0800
`define LCL_RAM_START 16'h1000
`define LCL_FLASH_START 16'h4000
`define LCL_PWIN_START 16'h8000
`define LCL_FIXED_TOP 16'hC000
`define LCL_EEP_FIXED_BIT 10
`define LCL_RAM_FIXED_BIT 13
`define LCL_RAM_HALF_BIT 12

`define EEP_FIXED_PAGE 8'hFF
`define RAM_FIXED_HI 7'h7F
`define PFL_LOW_FIXED_PAGE 8'hFD
`define PFL_TOP_FIXED_PAGE 8'hFF

`define EEP_OFF_W 10
`define RAM_OFF_W 12
`define PFL_OFF_W 14
`define GBL_EEP_BASE 23'h10_0000
`define GBL_EEP_END 23'h13_FFFF
`define GBL_RAM_BASE 23'h00_0000
`define GBL_RAM_START 23'h00_1000
`define GBL_RAM_END 23'h0F_FFFF
`define GBL_REG_END 23'h00_07FF
`define GBL_PFL_BASE 23'h40_0000
`define GBL_PFL_END 23'h7F_FFFF

`define STS_LOCK_BIT 0
`define STS_BLOCK_LSB 4

`endif

//--- rtl/page_window.sv
/*
 One paged window: global base plus page shifted by the window size
 plus the in-window offset.
 Assumes OFF_W is at most 14 and the result fits 23 bits.
*/
`timescale 1ns/10ps
module page_window #(
	parameter int OFF_W = 10,
	parameter logic [22:0] BASE = 23'h00_0000
) (
	window_if.window win
);
	wire [22:0] page_span;
	wire [22:0] offset_ext;

	// RULE17 base plus page
	assign page_span = 23'(win.page) << OFF_W;
	assign offset_ext = 23'(win.offset[OFF_W-1:0]);
	assign win.gaddr = BASE + page_span + offset_ext;
endmodule

//--- rtl/window_if.sv
/*
 Carrier between the mapper and one paged window translator.
 Assumes a single clock domain; purely combinational signals.
*/
`timescale 1ns/10ps
interface window_if;
	logic [7:0] page;
	logic [13:0] offset;
	logic [22:0] gaddr;

	modport user (
		output page,
		output offset,
		input gaddr
	);

	modport window (
		input page,
		input offset,
		output gaddr
	);
endinterface

//--- verification/core_model.sv
/*
 Core model issuing one local access per call.
 Assumes calls start only after the mapper leaves reset.
*/
`timescale 1ns/10ps
module core_model (
	input wire logic mclk_in,
	output logic lcl_req_out,
	output logic [15:0] lcl_addr_out,
	output logic lcl_global_out,
	output logic lcl_direct_out
);
	initial begin
		lcl_req_out = 1'b0;
		lcl_addr_out = 16'h0000;
		lcl_global_out = 1'b0;
		lcl_direct_out = 1'b0;
	end
	// Idle lines inverted so a stale value never looks held
	task automatic access(input logic [15:0] a, input logic g, input logic d);
		@(posedge mclk_in);
		lcl_req_out <= 1'b1;
		lcl_addr_out <= a;
		lcl_global_out <= g;
		lcl_direct_out <= d;
		@(posedge mclk_in);
		lcl_req_out <= 1'b0;
		lcl_addr_out <= ~a;
		lcl_global_out <= ~g;
		lcl_direct_out <= ~d;
	endtask
endmodule

//--- verification/mapper_checker.sv
/*
 Assertions on bus answer timing and local to global translation.
 Assumes one clock and binding to the mapper's top module.
*/
`timescale 1ns/10ps
module mapper_checker (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic avs_waitrequest_out,
	input wire logic lcl_req_in,
	input wire logic [15:0] lcl_addr_in,
	input wire logic lcl_global_in,
	input wire logic lcl_direct_in,
	input wire logic gbl_valid_out,
	input wire logic [22:0] gbl_addr_out,
	input wire logic [2:0] gbl_block_out
);
	default clocking @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);
	// Direct page is unseen here, so only plain accesses are mapped
	wire plain = lcl_req_in && !lcl_global_in && !lcl_direct_in;
	wire [15:0] a = lcl_addr_in;
	sequence s_answer;
		!avs_waitrequest_out ##1 avs_waitrequest_out;
	endsequence
	AST_ANSWER: assert property (
		(avs_read_in || avs_write_in) && avs_waitrequest_out |=> s_answer)
		else $error("bus answer not one cycle");
	AST_VALID: assert property (lcl_req_in |=> gbl_valid_out)
		else $error("valid missing");
	AST_QUIET: assert property (!lcl_req_in |=> !gbl_valid_out)
		else $error("valid without request");
	AST_GLOBAL: assert property (
		lcl_req_in && lcl_global_in |=> gbl_addr_out[15:0] == $past(lcl_addr_in))
		else $error("global low bits wrong");
	AST_REGS: assert property (plain && a < 16'h0800 |=>
		gbl_addr_out == {7'h00, $past(a)} && gbl_block_out == 3'h0)
		else $error("register map wrong");
	AST_EEP_FIXED: assert property (plain && a[15:10] == 6'h03 |=>
		gbl_addr_out == {13'h04FF, $past(a[9:0])} && gbl_block_out == 3'h2)
		else $error("fixed eeprom wrong");
	AST_EEP_WIN: assert property (plain && a[15:10] == 6'h02 |=>
		gbl_addr_out[22:18] == 5'h04 && gbl_addr_out[9:0] == $past(a[9:0]))
		else $error("eeprom window wrong");
	AST_RAM_FIXED: assert property (plain && a[15:13] == 3'h1 |=>
		gbl_addr_out == {10'h07F, $past(a[12:0])} && gbl_block_out == 3'h1)
		else $error("fixed ram wrong");
	AST_FLASH_FIXED: assert property (plain && a[14] |=>
		gbl_addr_out == {7'h7F, $past(a[15]), 1'b1, $past(a[13:0])})
		else $error("fixed flash wrong");
	AST_PWIN: assert property (plain && a[15:14] == 2'h2 |=>
		gbl_addr_out[22] && gbl_addr_out[13:0] == $past(a[13:0]) && gbl_block_out == 3'h3)
		else $error("program window wrong");
endmodule
bind local_global_address_mapper mapper_checker i_mapper_checker (
	.mclk_in(mclk_in), .rst_n_in(rst_n_in), .avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
	.lcl_req_in(lcl_req_in), .lcl_addr_in(lcl_addr_in), .lcl_global_in(lcl_global_in),
	.lcl_direct_in(lcl_direct_in), .gbl_valid_out(gbl_valid_out),
	.gbl_addr_out(gbl_addr_out), .gbl_block_out(gbl_block_out)
);

//--- verification/test_local_global_address_mapper.sv
/*
 Bench: page registers over the register bus, then translations.
 Assumes the core model and the bound checker.
*/
`timescale 1ns/10ps
module test_local_global_address_mapper;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [2:0] avs_address_in = 3'h0;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h00000000;
	logic [3:0] avs_byteenable_in = 4'hF;
	logic [31:0] avs_readdata_out;
	logic avs_waitrequest_out;
	logic lcl_req_in;
	logic [15:0] lcl_addr_in;
	logic lcl_global_in;
	logic lcl_direct_in;
	logic gbl_valid_out;
	logic [22:0] gbl_addr_out;
	logic [2:0] gbl_block_out;
	logic [7:0] rst_val [5] = '{8'h00, 8'h00, 8'hFE, 8'hFD, 8'hFE};
	int fails = 0;
	int tests_run = 0;
	initial begin
		forever #5 mclk_in = ~mclk_in;
	end
	local_global_address_mapper i_local_global_address_mapper (
		.mclk_in(mclk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
		.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
		.lcl_req_in(lcl_req_in), .lcl_addr_in(lcl_addr_in), .lcl_global_in(lcl_global_in),
		.lcl_direct_in(lcl_direct_in), .gbl_valid_out(gbl_valid_out),
		.gbl_addr_out(gbl_addr_out), .gbl_block_out(gbl_block_out)
	);
	core_model i_core_model (
		.mclk_in(mclk_in), .lcl_req_out(lcl_req_in), .lcl_addr_out(lcl_addr_in),
		.lcl_global_out(lcl_global_in), .lcl_direct_out(lcl_direct_in)
	);
	task automatic complete_run();
		$display("Checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			$display("Error %s expected %h seen %h", n, e, s);
			fails++;
		end
	endtask
	task automatic bus(input logic wr, input logic [2:0] ofs, input logic [7:0] wd,
		input logic [3:0] be, input logic [31:0] exp);
		int n;
		@(posedge mclk_in);
		avs_address_in <= ofs;
		avs_writedata_in <= {24'h000000, wd};
		avs_byteenable_in <= be;
		avs_write_in <= wr;
		avs_read_in <= !wr;
		n = 0;
		do begin
			@(posedge mclk_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 20);
		if (avs_waitrequest_out !== 1'b0) begin
			$display("Error waitrequest expected 0 seen %b", avs_waitrequest_out);
			fails++;
			complete_run();
		end
		if (!wr) chk("readdata", exp, avs_readdata_out);
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
	endtask
	task automatic xl(input logic [15:0] a, input logic g, input logic d,
		input logic [22:0] ea, input logic [2:0] eb);
		i_core_model.access(a, g, d);
		#1;
		chk("valid", 32'h00000001, {31'h00000000, gbl_valid_out});
		chk("gaddr", {9'h000, ea}, {9'h000, gbl_addr_out});
		chk("block", {29'h00000000, eb}, {29'h00000000, gbl_block_out});
	endtask
	initial begin
		repeat (10) @(posedge mclk_in);
		// Outputs must sit at their reset levels before release
		chk("rst_waitrequest", 32'h00000001, {31'h00000000, avs_waitrequest_out});
		chk("rst_readdata", 32'h00000000, avs_readdata_out);
		chk("rst_valid", 32'h00000000, {31'h00000000, gbl_valid_out});
		chk("rst_gaddr", 32'h00000000, {9'h000, gbl_addr_out});
		chk("rst_block", 32'h00000000, {29'h00000000, gbl_block_out});
		rst_n_in <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, i[2:0], 8'h00, 4'hF, {24'h000000, rst_val[i]});
		end
		bus(1'b1, 3'h7, 8'h55, 4'hF, 32'h00000000);
		bus(1'b0, 3'h7, 8'h00, 4'hF, 32'h00000000);
		bus(1'b1, 3'h1, 8'h11, 4'h0, 32'h00000000);
		bus(1'b0, 3'h1, 8'h00, 4'hF, 32'h00000000);
		bus(1'b1, 3'h1, 8'h2A, 4'hF, 32'h00000000);
		bus(1'b1, 3'h1, 8'h30, 4'hF, 32'h00000000);
		bus(1'b0, 3'h1, 8'h00, 4'hF, 32'h0000002A);
		bus(1'b0, 3'h5, 8'h00, 4'hF, 32'h00000001);
		bus(1'b1, 3'h0, 8'h3C, 4'hF, 32'h00000000);
		bus(1'b0, 3'h0, 8'h00, 4'hF, 32'h0000003C);
		bus(1'b1, 3'h2, 8'h05, 4'hF, 32'h00000000);
		bus(1'b1, 3'h3, 8'hF1, 4'hF, 32'h00000000);
		bus(1'b1, 3'h4, 8'h12, 4'hF, 32'h00000000);
		xl(16'h0123, 1'b0, 1'b0, 23'h000123, 3'h0);
		xl(16'h0C10, 1'b0, 1'b0, 23'h13FC10, 3'h2);
		xl(16'h0A05, 1'b0, 1'b0, 23'h101605, 3'h2);
		xl(16'h1ABC, 1'b0, 1'b0, 23'h0F1ABC, 3'h1);
		xl(16'h2345, 1'b0, 1'b0, 23'h0FE345, 3'h1);
		xl(16'h5678, 1'b0, 1'b0, 23'h7F5678, 3'h3);
		xl(16'h9ABC, 1'b0, 1'b0, 23'h449ABC, 3'h3);
		xl(16'hFFFF, 1'b0, 1'b0, 23'h7FFFFF, 3'h3);
		xl(16'h1234, 1'b1, 1'b1, 23'h3C1234, 3'h4);
		xl(16'hFF34, 1'b0, 1'b1, 23'h0FEA34, 3'h1);
		bus(1'b1, 3'h2, 8'hFF, 4'hF, 32'h00000000);
		bus(1'b1, 3'h3, 8'hFE, 4'hF, 32'h00000000);
		bus(1'b1, 3'h4, 8'hFD, 4'hF, 32'h00000000);
		xl(16'h0810, 1'b0, 1'b0, 23'h13FC10, 3'h2);
		xl(16'h1010, 1'b0, 1'b0, 23'h0FE010, 3'h1);
		xl(16'h8123, 1'b0, 1'b0, 23'h7F4123, 3'h3);
		// Last translation and its block class read back over the bus
		bus(1'b0, 3'h6, 8'h00, 4'hF, 32'h007F4123);
		bus(1'b0, 3'h5, 8'h00, 4'hF, 32'h00000031);
		bus(1'b0, 3'h2, 8'h00, 4'hF, 32'h000000FF);
		complete_run();
	end
endmodule
